// ==== rtl/tws_pkg.sv ====
// Purpose: Constants and types for the two-wire status flag block
// Assumes: 50 MHz clock, 8-bit special-function register port
package tws_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TWS_STATUS_ADDR   = 8'hdd;
  localparam logic [7:0] TWS_STATUS_RESET  = 8'h00;
  localparam logic [7:0] TWS_GEN_CALL_ADDR = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TWS_BIT_GEN_CALL = 7;
  localparam int TWS_BIT_STOP     = 6;
  localparam int TWS_BIT_PEND     = 5;
  localparam int TWS_BIT_TX       = 4;
  localparam int TWS_BIT_BUSY     = 3;
  localparam int TWS_BIT_LOST     = 2;
  localparam int TWS_BIT_NACK     = 1;
  localparam int TWS_BIT_SLAVE    = 0;
  localparam int TWS_NUM_IRQ      = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tws_sfr_t;

  // Engine events, one-cycle pulses except the levels noted and addr_byte
  typedef struct packed {
    logic                   is_slave;     // Level
    logic                   is_tx;        // Level
    logic                   addr_valid;   // Pulse, address byte received
    logic [7:0]             addr_byte;
    logic                   arb_lost;     // Pulse
    logic                   ack_sample;   // Pulse, acknowledge bit sampled
    logic [TWS_NUM_IRQ-1:0] irq_cond;     // Pulses
  } tws_evt_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic seen;
  } tws_det_t;

  typedef struct packed {
    logic       general_call_flag;
    logic       stop;
    logic       interrupt_pending_flag;
    logic       busy;
    logic       lost;
    logic       nack;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [7:0] rdata;
  } tws_state_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TWS_SYNC_IDLE = 2'h3;
  localparam tws_det_t   TWS_DET_RESET = '{scl_q: 1'b1, sda_q: 1'b1, seen: 1'b0};

endpackage

// ==== rtl/tws_cond_det.sv ====
// Purpose: Start and stop condition detector on synchronised lines
// Assumes: Inputs already synchronised to clk
// Notes:   Stop held while both lines idle high after a stop edge
`timescale 1ns/1ps
`default_nettype none
module tws_cond_det (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Lines
  input  wire logic scl,
  input  wire logic sda,
  // Conditions
  output logic      start_det,
  output logic      stop_det,
  output logic      stop_level
);

  tws_pkg::tws_det_t st_r;
  tws_pkg::tws_det_t st_nxt;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.scl_q = scl;
    st_nxt.sda_q = sda;
    if (stop_det)
      st_nxt.seen = 1'b1;
    else if (start_det || !scl || !sda)
      st_nxt.seen = 1'b0;
  end

  assign start_det  = st_r.scl_q && scl && st_r.sda_q && !sda;
  assign stop_det   = st_r.scl_q && scl && !st_r.sda_q && sda;
  assign stop_level = stop_det || (st_r.seen && scl && sda);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= tws_pkg::TWS_DET_RESET;
    else if (clk_en)
      st_r <= st_nxt;
  end

endmodule
`default_nettype wire

// ==== rtl/tws_status.sv ====
// Purpose: Status register of the two-wire serial engine
// Assumes: Engine events arrive on clk; bus lines are asynchronous pins
// Notes:   Only the pending flag is writable
`timescale 1ns/1ps
`default_nettype none
module tws_status (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Register port
  input  wire tws_pkg::tws_sfr_t sfr,
  output logic [7:0]             sfr_rdata,
  output logic                   sfr_hit,
  // Bus lines
  input  wire logic              scl_pin,
  input  wire logic              sda_pin,
  // Engine
  input  wire tws_pkg::tws_evt_t evt,
  output logic                   irq
);

  tws_pkg::tws_state_t st_r;
  tws_pkg::tws_state_t st_nxt;
  logic start_det;
  logic stop_det;
  logic stop_level;
  logic any_irq;
  logic wr_hit;
  logic rd_hit;
  logic pend_clr;
  logic [7:0] status;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hits_status(input logic [7:0] addr);
    hits_status = (addr == tws_pkg::TWS_STATUS_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Condition detector
  // ----------------------------------------------------------------
  tws_cond_det u_det (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .scl        (st_r.scl_sync[1]),
    .sda        (st_r.sda_sync[1]),
    .start_det  (start_det),
    .stop_det   (stop_det),
    .stop_level (stop_level)
  );

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------
  assign any_irq  = |evt.irq_cond;
  assign wr_hit   = sfr.wr && hits_status(sfr.addr);
  assign rd_hit   = sfr.rd && hits_status(sfr.addr);
  assign pend_clr = wr_hit && !sfr.wdata[tws_pkg::TWS_BIT_PEND];

  always_comb
  begin
    status = {st_r.general_call_flag, st_r.stop, st_r.interrupt_pending_flag, evt.is_tx,
              st_r.busy, st_r.lost, st_r.nack, evt.is_slave};
    st_nxt = st_r;
    st_nxt.scl_sync = {st_r.scl_sync[0], scl_pin};
    st_nxt.sda_sync = {st_r.sda_sync[0], sda_pin};
    if (start_det || stop_det)
      st_nxt.general_call_flag = 1'b0;
    else if (evt.is_slave && evt.addr_valid && evt.addr_byte == tws_pkg::TWS_GEN_CALL_ADDR)
      st_nxt.general_call_flag = 1'b1;
    st_nxt.stop = stop_level;
    if (any_irq)
      st_nxt.interrupt_pending_flag = 1'b1;
    else if (pend_clr)
      st_nxt.interrupt_pending_flag = 1'b0;
    if (start_det)
      st_nxt.busy = 1'b1;
    else if (stop_det)
      st_nxt.busy = 1'b0;
    if (!evt.is_slave && (evt.arb_lost || st_r.general_call_flag))
      st_nxt.lost = 1'b1;
    else if (start_det && evt.is_slave)
      st_nxt.lost = 1'b0;
    if (evt.is_tx && evt.ack_sample)
      st_nxt.nack = st_r.sda_sync[1];
    st_nxt.rdata = rd_hit ? status : st_r.rdata;
  end

  // No stop is launched here on nack; firmware requests it.
  assign sfr_rdata = st_r.rdata;
  assign sfr_hit   = hits_status(sfr.addr);
  assign irq       = st_r.interrupt_pending_flag;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r          <= '0;
      st_r.scl_sync <= tws_pkg::TWS_SYNC_IDLE;
      st_r.sda_sync <= tws_pkg::TWS_SYNC_IDLE;
      st_r.rdata    <= tws_pkg::TWS_STATUS_RESET;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pend_sets: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && any_irq |=> st_r.interrupt_pending_flag) else $error("pending flag not set");
  a_pend_holds: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_r.interrupt_pending_flag && !wr_hit |=> st_r.interrupt_pending_flag)
    else $error("pending flag self cleared");
  a_busy_start: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && start_det |=> st_r.busy) else $error("busy not set on start");
  a_busy_stop: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && stop_det && !start_det |=> !st_r.busy) else $error("busy not cleared");
  a_gencall_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && (start_det || stop_det) |=> !st_r.general_call_flag)
    else $error("general call flag not cleared");
  a_gencall_lost: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_r.general_call_flag && !evt.is_slave |=> st_r.lost)
    else $error("lost not set on general call");
  a_arb_lost: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && evt.arb_lost && !evt.is_slave |=> st_r.lost) else $error("lost missed");
  a_stop_flag: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && stop_det |=> st_r.stop) else $error("stop flag missed");
  a_nack_take: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && evt.is_tx && evt.ack_sample |=> st_r.nack == $past(st_r.sda_sync[1]))
    else $error("nack wrong");

  // ----------------------------------------------------------------
  // Checks: read port and clock enable
  // ----------------------------------------------------------------
  a_read_load: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && rd_hit |=> sfr_rdata == $past(status))
    else $error("read data not loaded");

  a_read_hold: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !rd_hit |=> $stable(sfr_rdata))
    else $error("read data changed without read");

  a_read_tx: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && rd_hit |=> sfr_rdata[tws_pkg::TWS_BIT_TX] == $past(evt.is_tx))
    else $error("transmit role bit wrong");

  a_read_slave: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && rd_hit |=> sfr_rdata[tws_pkg::TWS_BIT_SLAVE] == $past(evt.is_slave))
    else $error("slave role bit wrong");

  a_freeze_state: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(st_r))
    else $error("state moved while frozen");

  // ----------------------------------------------------------------
  // Checks: pending flag
  // ----------------------------------------------------------------
  a_pend_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && pend_clr && !any_irq |=> !st_r.interrupt_pending_flag)
    else $error("pending flag not cleared");

  a_pend_no_self: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !st_r.interrupt_pending_flag && !any_irq |=> !st_r.interrupt_pending_flag)
    else $error("pending flag set without cause");

  a_pend_write_one: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_r.interrupt_pending_flag && !pend_clr |=> st_r.interrupt_pending_flag)
    else $error("pending flag lost on write");

  a_irq_follows: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && any_irq |=> irq)
    else $error("irq not raised");

  // ----------------------------------------------------------------
  // Checks: bus and role flags
  // ----------------------------------------------------------------
  a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !start_det && !stop_det |=> $stable(st_r.busy))
    else $error("busy changed without condition");

  a_stop_low: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !st_r.scl_sync[1] |=> !st_r.stop)
    else $error("stop flag with clock low");

  a_gencall_set: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && evt.is_slave && evt.addr_valid && !start_det && !stop_det &&
    evt.addr_byte == tws_pkg::TWS_GEN_CALL_ADDR |=> st_r.general_call_flag)
    else $error("general call flag not set");

  a_gencall_master: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !evt.is_slave && !st_r.general_call_flag |=> !st_r.general_call_flag)
    else $error("general call flag set as master");

  a_gencall_hold: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !start_det && !stop_det && !evt.addr_valid |=> $stable(st_r.general_call_flag))
    else $error("general call flag changed");

  a_lost_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && st_r.lost && !(start_det && evt.is_slave) |=> st_r.lost)
    else $error("lost flag dropped");

  a_lost_slave: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && evt.is_slave && !st_r.lost |=> !st_r.lost)
    else $error("lost flag set as slave");

  a_nack_hold: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !(evt.is_tx && evt.ack_sample) |=> $stable(st_r.nack))
    else $error("nack changed without sample");

endmodule
`default_nettype wire

// ==== test/tws_bus_model.sv ====
// Purpose: Two-wire bus partner
// Assumes: Pulled-up lines
// Notes:   Lines idle high
`timescale 1ns/1ps
`default_nettype none
module tws_bus_model (
  // Clock
  input  wire logic clk,
  // Lines
  output logic      scl,
  output logic      sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic drv(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    sda <= d;
    repeat (3) @(posedge clk);
  endtask
  task automatic start_c();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask
  // Stop only on request
  task automatic stop_c();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== test/test_tws_status.sv ====
// Purpose: Register bench for the status flags
// Assumes: Bus partner makes start and stop
// Notes:   Fixed waits only
`timescale 1ns/1ps
`default_nettype none
module test_tws_status;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              clk_en = 1'b1;
  tws_pkg::tws_sfr_t sfr = '0;
  tws_pkg::tws_evt_t evt = '0;
  logic [7:0]        rdata;
  logic              hit;
  logic              irq;
  logic              scl;
  logic              sda;
  int                fail_count = 0;
  int                n_compared = 0;
  always #10 clk = ~clk;
  tws_bus_model bus (.clk(clk), .scl(scl), .sda(sda));
  tws_status dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sfr(sfr), .sfr_rdata(rdata),
    .sfr_hit(hit), .scl_pin(scl), .sda_pin(sda), .evt(evt), .irq(irq)
  );
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clk);
    sfr <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: d};
    #1;
  endtask
  task automatic rd(input logic [7:0] exp);
    acc(1'b1, 1'b0, tws_pkg::TWS_STATUS_ADDR, 8'h00);
    check("status", rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] p);
    @(posedge clk);
    {evt.addr_valid, evt.arb_lost, evt.ack_sample, evt.irq_cond} <= p;
    @(posedge clk);
    {evt.addr_valid, evt.arb_lost, evt.ack_sample, evt.irq_cond} <= 8'h00;
  endtask
  task automatic lv(input logic s, input logic t);
    @(posedge clk);
    evt.is_slave <= s;
    evt.is_tx <= t;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00);
    check("hit", {7'h00, hit}, 8'h01);
    acc(1'b1, 1'b0, 8'hde, 8'h00);
    check("hit", {7'h00, hit}, 8'h00);
    lv(1'b1, 1'b1);
    rd(8'h11);
    lv(1'b1, 1'b0);
    evt.addr_byte <= 8'h5a;
    bus.start_c();
    rd(8'h09);
    pulse(8'h80);
    rd(8'h09);
    lv(1'b1, 1'b0);
    evt.addr_byte <= 8'h00;
    pulse(8'h80);
    rd(8'h89);
    bus.stop_c();
    rd(8'h41);
    bus.start_c();
    pulse(8'h80);
    lv(1'b0, 1'b0);
    rd(8'h8c);
    bus.stop_c();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    lv(1'b0, 1'b1);
    bus.start_c();
    rd(8'h18);
    pulse(8'h40);
    rd(8'h1c);
    bus.drv(1'b0, 1'b1);
    pulse(8'h20);
    rd(8'h1e);
    rd(8'h1e);
    bus.drv(1'b0, 1'b0);
    pulse(8'h20);
    rd(8'h1c);
    for (int i = 0; i < 5; i++)
    begin
      pulse(8'h01 << i);
      rd(8'h3c);
      check("irq", {7'h00, irq}, 8'h01);
      acc(1'b0, 1'b1, tws_pkg::TWS_STATUS_ADDR, 8'hff);
      rd(8'h3c);
      acc(1'b0, 1'b1, tws_pkg::TWS_STATUS_ADDR, 8'h00);
      rd(8'h1c);
      check("irq", {7'h00, irq}, 8'h00);
    end
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(8'h01);
    clk_en <= 1'b1;
    rd(8'h1c);
    @(posedge clk);
    sfr <= '{rd: 1'b0, wr: 1'b1, addr: tws_pkg::TWS_STATUS_ADDR, wdata: 8'h00};
    evt.irq_cond <= 5'h10;
    @(posedge clk);
    sfr.wr <= 1'b0;
    evt.irq_cond <= 5'h00;
    rd(8'h3c);
    results();
  end
endmodule
`default_nettype wire
